// >>> src/scwp_consts.svh
/*
  Constants of the serial control write port: register file size,
  frame lengths, target addresses and reset levels.
  Assumes inclusion by the package and by the port module.
*/
`ifndef SCWP_CONSTS_SVH
`define SCWP_CONSTS_SVH

`define SCWP_REG_W 8
`define SCWP_NUM_REGS 23
`define SCWP_LAST_ADDR 8'h16
`define SCWP_REG_RESET 8'h00
`define SCWP_SPI_FRAME_BITS 5'h10
`define SCWP_SPI_CNT_MAX 5'h11
`define SCWP_SPI_ADDR_MSB 15
`define SCWP_SPI_ADDR_LSB 8
`define SCWP_SPI_DATA_MSB 7
`define SCWP_I2C_BYTE_BITS 4'h8
`define SCWP_DEV_ADDR_STRAP_LOW 7'h10
`define SCWP_DEV_ADDR_STRAP_HIGH 7'h70
`define SCWP_PIN_SYNC_RESET 4'hd

`endif

// >>> src/scwp_pkg.sv
/*
  Types of the serial control write port.
  Assumes scwp_consts.svh is on the include path.
*/
`include "scwp_consts.svh"

package scwp_pkg;

  // ==========================================================
  // Two-wire target states
  typedef enum logic [2:0]
  {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_ACK_ADDR = 3'b010,
    I2C_REG = 3'b011,
    I2C_ACK_REG = 3'b100,
    I2C_DATA = 3'b101,
    I2C_ACK_DATA = 3'b110
  } scwp_i2c_st_e;

  // ==========================================================
  // Register write event and register file
  typedef struct packed
  {
    logic valid;
    logic [7:0] addr;
    logic [`SCWP_REG_W-1:0] data;
  } scwp_wr_s;

  typedef logic [`SCWP_NUM_REGS-1:0][`SCWP_REG_W-1:0] scwp_regfile_t;

endpackage

// >>> src/scwp_top.sv
/*
  Serial control write port: write-only 8-bit configuration registers
  loaded over a three-wire or a two-wire serial link.
  Assumes all pins are asynchronous to i_clk_sys, which runs well
  above eight times the link clock so every link edge is seen.
*/
// Overview of operation
// - Strap low selects two-wire link, strap high selects three-wire.
// - Device is only a target; host makes every transfer and clock.
// - Configuration lives in 8-bit write-only registers, no read path.
// - Select low frames a transfer; data sampled on serial clock rise.
// - Three-wire frame is sixteen bits, most significant bit first.
// - Frame bits 15:8 are register address, bits 7:0 the new value.
// - All registers hold zero from power-up until written.
// - Two-wire address is 0010000 or 1110000 per address strap.
`timescale 1ns/1ns
`default_nettype none
`include "scwp_consts.svh"

module scwp_top
(
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // Straps and link pins
  input wire logic i_mode_strap,
  input wire logic i_address_strap_or_select_pin,
  input wire logic i_scl_sck,
  input wire logic i_sda_sdi,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Register file side
  output scwp_pkg::scwp_regfile_t o_regs,
  output scwp_pkg::scwp_wr_s o_wr,
  output logic o_frame_drop
);

  // ==========================================================
  // Decoding helpers
  function automatic logic is_ack(input scwp_pkg::scwp_i2c_st_e st);
    is_ack = (st == scwp_pkg::I2C_ACK_ADDR) ||
             (st == scwp_pkg::I2C_ACK_REG) ||
             (st == scwp_pkg::I2C_ACK_DATA);
  endfunction

  function automatic logic in_range(input logic [7:0] addr);
    in_range = (addr <= `SCWP_LAST_ADDR);
  endfunction

  // ==========================================================
  // Pin synchronisers: {mode, sel/addr, scl/sck, sda/sdi}
  logic [3:0] pin_m_r;
  logic [3:0] pin_s_r;
  logic scl_d_r;
  logic sda_d_r;
  logic sel_d_r;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pin_m_r <= `SCWP_PIN_SYNC_RESET;
      pin_s_r <= `SCWP_PIN_SYNC_RESET;
      // Matches the synchroniser's reset level so no false edge follows
      scl_d_r <= 1'b0;
      sda_d_r <= 1'b1;
      sel_d_r <= 1'b1;
    end
    else if (i_clk_en)
    begin
      pin_m_r <= {i_mode_strap, i_address_strap_or_select_pin,
                  i_scl_sck, i_sda_sdi};
      pin_s_r <= pin_m_r;
      scl_d_r <= pin_s_r[1];
      sda_d_r <= pin_s_r[0];
      sel_d_r <= pin_s_r[2];
    end
  end

  logic mode_spi;
  logic sel_s;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic sel_rise;

  assign mode_spi = pin_s_r[3];
  assign sel_s = pin_s_r[2];
  assign scl_s = pin_s_r[1];
  assign sda_s = pin_s_r[0];
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign sel_rise = sel_s && !sel_d_r;

  // ==========================================================
  // Three-wire receiver
  logic [15:0] spi_sh_r;
  logic [4:0] spi_cnt_r;
  logic spi_active;
  logic spi_commit;
  logic spi_drop;

  assign spi_active = mode_spi && !sel_s;
  assign spi_commit = mode_spi && sel_rise &&
                      (spi_cnt_r == `SCWP_SPI_FRAME_BITS);
  assign spi_drop = mode_spi && sel_rise && (spi_cnt_r != 5'h00) &&
                    (spi_cnt_r != `SCWP_SPI_FRAME_BITS);

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      spi_sh_r <= 16'h0000;
      spi_cnt_r <= 5'h00;
    end
    else if (i_clk_en)
    begin
      if (!spi_active)
        spi_cnt_r <= 5'h00;
      else if (scl_rise)
      begin
        spi_sh_r <= {spi_sh_r[14:0], sda_s};
        // Saturating keeps an overlong frame from wrapping to sixteen
        if (spi_cnt_r != `SCWP_SPI_CNT_MAX)
          spi_cnt_r <= spi_cnt_r + 5'h01;
      end
    end
  end

  // ==========================================================
  // Two-wire target
  scwp_pkg::scwp_i2c_st_e i2c_st_r;
  scwp_pkg::scwp_i2c_st_e i2c_st_nxt;
  logic [7:0] i2c_sh_r;
  logic [3:0] i2c_cnt_r;
  logic [7:0] i2c_ptr_r;
  logic [6:0] dev_addr;
  logic i2c_start;
  logic i2c_stop;
  logic i2c_byte;
  logic i2c_commit;

  assign dev_addr = sel_s ? `SCWP_DEV_ADDR_STRAP_HIGH
                          : `SCWP_DEV_ADDR_STRAP_LOW;
  assign i2c_start = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign i2c_stop = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign i2c_byte = scl_fall && (i2c_cnt_r == `SCWP_I2C_BYTE_BITS);
  assign i2c_commit = !mode_spi && !i2c_stop && !i2c_start && i2c_byte &&
                      (i2c_st_r == scwp_pkg::I2C_DATA);

  always_comb
  begin
    i2c_st_nxt = i2c_st_r;
    if (mode_spi || i2c_stop)
      i2c_st_nxt = scwp_pkg::I2C_IDLE;
    else if (i2c_start)
      i2c_st_nxt = scwp_pkg::I2C_ADDR;
    else if (scl_fall)
    begin
      case (i2c_st_r)
        scwp_pkg::I2C_ADDR:
          if (i2c_byte)
            // Read requests are refused: nothing can be read back
            i2c_st_nxt = (i2c_sh_r[7:1] == dev_addr && !i2c_sh_r[0]) ?
                         scwp_pkg::I2C_ACK_ADDR :
                         scwp_pkg::I2C_IDLE;
        scwp_pkg::I2C_REG:
          if (i2c_byte)
            i2c_st_nxt = scwp_pkg::I2C_ACK_REG;
        scwp_pkg::I2C_DATA:
          if (i2c_byte)
            i2c_st_nxt = scwp_pkg::I2C_ACK_DATA;
        scwp_pkg::I2C_ACK_ADDR:
          i2c_st_nxt = scwp_pkg::I2C_REG;
        scwp_pkg::I2C_ACK_REG:
          i2c_st_nxt = scwp_pkg::I2C_DATA;
        scwp_pkg::I2C_ACK_DATA:
          i2c_st_nxt = scwp_pkg::I2C_DATA;
        default:
          i2c_st_nxt = i2c_st_r;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      i2c_st_r <= scwp_pkg::I2C_IDLE;
    else if (i_clk_en)
      i2c_st_r <= i2c_st_nxt;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      i2c_sh_r <= 8'h00;
      i2c_cnt_r <= 4'h0;
    end
    else if (i_clk_en)
    begin
      if (i2c_st_nxt != i2c_st_r)
        i2c_cnt_r <= 4'h0;
      else if (scl_rise && !is_ack(i2c_st_r) &&
               i2c_cnt_r != `SCWP_I2C_BYTE_BITS)
      begin
        i2c_sh_r <= {i2c_sh_r[6:0], sda_s};
        i2c_cnt_r <= i2c_cnt_r + 4'h1;
      end
    end
  end

  // Further data bytes in one transfer fill consecutive registers
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      i2c_ptr_r <= 8'h00;
    else if (i_clk_en)
    begin
      if (i2c_st_r == scwp_pkg::I2C_REG && i2c_st_nxt ==
          scwp_pkg::I2C_ACK_REG)
        i2c_ptr_r <= i2c_sh_r;
      else if (i2c_commit)
        i2c_ptr_r <= i2c_ptr_r + 8'h01;
    end
  end

  // Only the acknowledge slot is ever driven, and only low
  logic sda_oe_r;
  logic sda_out_r;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      sda_oe_r <= is_ack(i2c_st_nxt);
      sda_out_r <= 1'b0;
    end
  end

  // ==========================================================
  // Write event and register file
  scwp_pkg::scwp_wr_s wr_r;
  logic drop_r;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_r <= '0;
      drop_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      drop_r <= spi_drop;
      if (spi_commit)
      begin
        wr_r.valid <= in_range(
          spi_sh_r[`SCWP_SPI_ADDR_MSB:`SCWP_SPI_ADDR_LSB]);
        wr_r.addr <= spi_sh_r[`SCWP_SPI_ADDR_MSB:`SCWP_SPI_ADDR_LSB];
        wr_r.data <= spi_sh_r[`SCWP_SPI_DATA_MSB:0];
      end
      else if (i2c_commit)
      begin
        wr_r.valid <= in_range(i2c_ptr_r);
        wr_r.addr <= i2c_ptr_r;
        wr_r.data <= i2c_sh_r;
      end
      else
        wr_r.valid <= 1'b0;
    end
  end

  scwp_pkg::scwp_regfile_t regs_r;

  genvar gi;
  generate
    for (gi = 0; gi < `SCWP_NUM_REGS; gi = gi + 1)
    begin : g_reg
      always_ff @(posedge i_clk_sys or negedge i_resetn)
      begin
        if (!i_resetn)
          regs_r[gi] <= `SCWP_REG_RESET;
        else if (i_clk_en && wr_r.valid && wr_r.addr == 8'(gi))
          regs_r[gi] <= wr_r.data;
      end
    end
  endgenerate

  assign o_regs = regs_r;
  assign o_wr = wr_r;
  assign o_frame_drop = drop_r;
  assign o_sda_oe = sda_oe_r;
  assign o_sda_out = sda_out_r;

  // ==========================================================
  // Checks
  logic seen_r;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      seen_r <= 1'b0;
    else if (i_clk_en)
      seen_r <= 1'b1;
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  a_spi_no_drive: assert property (
    $past(i_clk_en) && $past(mode_spi) |-> !o_sda_oe)
    else $error("data pin driven in three-wire mode");
  a_oe_ack_only: assert property (
    o_sda_oe |-> is_ack(i2c_st_r) && !mode_spi)
    else $error("data pin driven outside an acknowledge");
  a_shift_msb: assert property (
    i_clk_en && spi_active && scl_rise |=>
      spi_sh_r == {$past(spi_sh_r[14:0]), $past(sda_s)})
    else $error("three-wire shift wrong");
  a_sel_clears: assert property (
    i_clk_en && sel_s |=> spi_cnt_r == 5'h00)
    else $error("bit count kept while select high");
  a_frame_fields: assert property (
    i_clk_en && spi_commit |=>
      wr_r.addr == $past(spi_sh_r[15:8]) &&
      wr_r.data == $past(spi_sh_r[7:0]))
    else $error("frame fields misplaced");
  a_len_discard: assert property (
    i_clk_en && mode_spi && sel_rise &&
      spi_cnt_r != `SCWP_SPI_FRAME_BITS |=>
      !o_wr.valid)
    else $error("frame of wrong length committed");
  a_reg_store: assert property (
    i_clk_en && wr_r.valid |=> o_regs[$past(wr_r.addr)] == $past(wr_r.data))
    else $error("register not updated");
  a_reset_zero: assert property (
    !seen_r |-> o_regs == '0 && !o_wr.valid)
    else $error("register not zero after reset");
  a_addr_match: assert property (
    i_clk_en && i2c_st_r == scwp_pkg::I2C_ADDR &&
      i2c_st_nxt == scwp_pkg::I2C_ACK_ADDR |->
      i2c_sh_r == {dev_addr, 1'b0})
    else $error("two-wire address acknowledged wrongly");

  c_spi_write: cover property (i_clk_en && spi_commit);
  c_spi_drop: cover property (i_clk_en && spi_drop);
  c_i2c_ack: cover property (o_sda_oe && i2c_st_r == scwp_pkg::I2C_ACK_ADDR);
  c_i2c_write: cover property (i_clk_en && i2c_commit);

endmodule
`default_nettype wire

// >>> tb/scwp_host.sv
/*
  Host model: drives three-wire frames and two-wire writes.
  Assumes the bench feeds back the resolved SDA level.
*/
`timescale 1ns/1ns
`default_nettype none

module scwp_host
(
  // Clock and line level
  input wire logic i_clk,
  input wire logic i_sda,
  // Link pins
  output logic o_sck,
  output logic o_sel_n,
  output logic o_dat
);
  logic ack;

  initial
  begin
    o_sck = 1'b0;
    o_sel_n = 1'b1;
    o_dat = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // ========
  // Three-wire frame, n bits
  task automatic spi(input logic [15:0] w, input int n);
    o_sel_n = 1'b0;
    wt(4);
    for (int i = 0; i < n; i++)
    begin
      o_dat = (i < 16) ? w[15-i] : 1'b0;
      wt(4);
      o_sck = 1'b1;
      wt(4);
      o_sck = 1'b0;
    end
    wt(4);
    o_sel_n = 1'b1;
    // Released line must not show the last bit
    o_dat = ~o_dat;
    wt(4);
  endtask

  // ========
  // Two-wire write
  task automatic bit2(input logic b);
    o_dat = b;
    wt(2);
    o_sck = 1'b1;
    wt(2);
    ack = ~i_sda;
    wt(2);
    o_sck = 1'b0;
    wt(2);
  endtask

  task automatic byte2(input logic [7:0] v, output logic a);
    for (int i = 7; i >= 0; i--)
      bit2(v[i]);
    bit2(1'b1);
    a = ack;
  endtask

  task automatic i2c(input logic [6:0] dev, input logic [7:0] r,
    input logic [7:0] d, output logic [2:0] a);
    o_sck = 1'b1;
    o_dat = 1'b1;
    wt(4);
    o_dat = 1'b0;
    wt(4);
    o_sck = 1'b0;
    wt(2);
    byte2({dev, 1'b0}, a[2]);
    byte2(r, a[1]);
    byte2(d, a[0]);
    o_dat = 1'b0;
    wt(2);
    o_sck = 1'b1;
    wt(4);
    o_dat = 1'b1;
    wt(4);
  endtask
endmodule

`default_nettype wire

// >>> tb/test_serial_control_write_port.sv
/*
  Bench: reference register file checked after every transfer.
  Assumes scwp_top and the scwp_host model.
*/
`timescale 1ns/1ns
`default_nettype none

module test_serial_control_write_port;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic mode = 1'b1;
  logic strap = 1'b0;
  logic sck, sel_n, dat, sda_w, pin, sda_out, sda_oe, drop;
  logic [2:0] acks;
  scwp_pkg::scwp_regfile_t regs;
  scwp_pkg::scwp_wr_s wr;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int n_wr = 0;
  int n_drop = 0;
  int exp_regs [23];

  always #5 clk = ~clk;
  // Open-drain: device pulls low while enabled
  assign sda_w = dat & ~(sda_oe & ~sda_out);
  assign pin = mode ? sel_n : strap;

  scwp_top scwp_top_i
  (
    .i_clk_sys(clk),
    .i_resetn(resetn),
    .i_clk_en(1'b1),
    .i_mode_strap(mode),
    .i_address_strap_or_select_pin(pin),
    .i_scl_sck(sck),
    .i_sda_sdi(sda_w),
    .o_sda_out(sda_out),
    .o_sda_oe(sda_oe),
    .o_regs(regs),
    .o_wr(wr),
    .o_frame_drop(drop)
  );

  scwp_host scwp_host_i
  (
    .i_clk(clk),
    .i_sda(sda_w),
    .o_sck(sck),
    .o_sel_n(sel_n),
    .o_dat(dat)
  );

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (wr.valid === 1'b1)
      n_wr <= n_wr + 1;
    if (drop === 1'b1)
      n_drop <= n_drop + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end

  // ========
  // Compare helpers
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic chk_regs();
    for (int i = 0; i < 23; i++)
      chk(regs[i] === exp_regs[i][7:0], "register value");
  endtask

  task automatic settle();
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input logic m, input logic s);
    resetn = 1'b0;
    mode = m;
    strap = s;
    repeat (5) @(posedge clk);
    #1;
    resetn = 1'b1;
    foreach (exp_regs[i])
      exp_regs[i] = 0;
    settle();
    chk_regs();
  endtask

  // ========
  // Transfers against the model
  task automatic spi_wr(input logic [7:0] a, input logic [7:0] d,
    input int n);
    int w0;
    int d0;
    logic ok;
    w0 = n_wr;
    d0 = n_drop;
    ok = (n == 16) && (a <= 8'h16);
    scwp_host_i.spi({a, d}, n);
    settle();
    if (ok)
      exp_regs[a] = d;
    chk((n_wr - w0) == (ok ? 1 : 0), "write pulse");
    chk((n_drop - d0) == (n != 16 ? 1 : 0), "frame drop");
    chk(sda_oe === 1'b0, "data pin driven");
    chk(sda_out === 1'b0, "data pin value");
    if (n == 16)
      chk(wr.addr === a && wr.data === d, "write fields");
    chk_regs();
  endtask

  task automatic i2c_wr(input logic [6:0] dev, input logic [7:0] r,
    input logic [7:0] d);
    logic hit;
    hit = (dev == (strap ? 7'h70 : 7'h10));
    scwp_host_i.i2c(dev, r, d, acks);
    settle();
    if (hit)
      exp_regs[r] = d;
    chk(acks === (hit ? 3'b111 : 3'b000), "acknowledge");
    chk_regs();
  endtask

  initial
  begin
    void'($urandom(19));
    do_reset(1'b1, 1'b0);
    for (int k = 0; k < 24; k++)
      spi_wr(8'($urandom_range(22)), 8'($urandom), 16);
    spi_wr(8'h16, 8'ha5, 16);
    spi_wr(8'h17, 8'h5a, 16);
    spi_wr(8'h03, 8'h3c, 15);
    spi_wr(8'h03, 8'hc3, 17);
    do_reset(1'b0, 1'b0);
    i2c_wr(7'h10, 8'h05, 8'($urandom));
    i2c_wr(7'h70, 8'h06, 8'h77);
    do_reset(1'b0, 1'b1);
    i2c_wr(7'h70, 8'h15, 8'h81);
    i2c_wr(7'h10, 8'h02, 8'h18);
    stop_test();
  end
endmodule

`default_nettype wire
